// file: dv/phy_strap_latch_test.sv
// testbench: strap sets latched through both resets, checked at ports and over apb
// assumes psl_strap_model on the pins and the bound checker
`timescale 1ns/1ps
module phy_strap_latch_test;
  import psl_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic chip_rst_pin_n = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, mgmt_addr_hit, cfg_reserved, straps_done;
  logic [NPINS-1:0] strap_in, strap_out, strap_oe, lv;
  logic [NPINS-1:0] func_out = 10'h2A5;
  logic drv = 1'b0;
  logic [4:0] mgmt_req_addr = '0;
  logic [4:0] mgmt_addr;
  psl_mode_e if_mode;
  logic [15:0] ctrl_word, adv_word;
  int err_count = 0;
  int tests_run = 0;
  logic [NPINS-1:0] lvs [4] = '{10'h047, 10'h3A3, 10'h0B5, 10'h22A};
  psl_mode_e mds [4] = '{MODE_MII, MODE_PRE_RESTORE, MODE_B2B, MODE_RSVD};
  logic [31:0] rd;
  logic er;
  always #50 clk = ~clk;
  psl_strap_latch dut (.clk(clk), .resetn(resetn), .chip_rst_pin_n(chip_rst_pin_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe), .func_out(func_out),
    .mgmt_req_addr(mgmt_req_addr), .mgmt_addr_hit(mgmt_addr_hit), .mgmt_addr(mgmt_addr), .if_mode(if_mode),
    .cfg_reserved(cfg_reserved), .ctrl_word(ctrl_word), .adv_word(adv_word), .straps_done(straps_done));
  psl_strap_model brd (.drv(drv), .lv(lv), .strap_oe(strap_oe), .strap_out(strap_out), .strap_in(strap_in));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic hit(input logic [4:0] a, input logic e);
    mgmt_req_addr <= a;
    repeat (2) @(posedge clk);
    chk(mgmt_addr_hit, e);
  endtask
  task automatic boot(input logic d, input logic [NPINS-1:0] l, input logic pin);
    int n;
    @(posedge clk);
    drv <= d;
    lv <= l;
    func_out <= ~l;
    if (pin) chip_rst_pin_n <= 1'b0;
    else resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    chip_rst_pin_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, ADDR_CTRL, 32'h0000FFFF);
    chk(er, 1'b1);
    n = 0;
    while (straps_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      tally_and_finish();
    end
    drv <= 1'b0;
  endtask
  task automatic check_all(input logic [NPINS-1:0] l, input psl_mode_e m);
    logic rs;
    rs = (m == MODE_RSVD);
    chk(mgmt_addr, {2'b00, l[2:0]});
    chk(if_mode, m);
    chk(cfg_reserved, rs);
    chk(ctrl_word, {2'b00, l[7], l[9], 1'b0, l[6], 1'b0, l[8], 8'h00});
    chk(adv_word, {7'h00, l[7], l[7], 2'b11, 5'h01});
    chk(strap_oe, 10'h3FF);
    chk(strap_out, func_out);
    apb(1'b0, ADDR_STRAP, 32'h0);
    chk(rd, {15'h0, 1'b1, 4'h0, rs, l[5:3], 3'h0, 2'b00, l[2:0]});
    hit(MGMT_BCAST, 1'b1);
    hit({2'b00, l[2:0]}, 1'b1);
    hit({2'b01, l[2:0]}, 1'b0);
  endtask
  initial begin
    boot(1'b0, PIN_PULL_LEVELS, 1'b0);
    check_all(PIN_PULL_LEVELS, MODE_MII);
    $display("pull defaults done");
    apb(1'b1, ADDR_CTRL, 32'h00000100);
    chk(er, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h00000100);
    chk(ctrl_word, 16'h0100);
    apb(1'b1, ADDR_ADV, 32'hFFFF_01E1);
    chk(er, 1'b0);
    apb(1'b0, ADDR_ADV, 32'h0);
    chk(rd, 32'h0000_01E1);
    chk(adv_word, 16'h01E1);
    apb(1'b1, ADDR_STRAP, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("register access done");
    // odd sets relatch through the chip reset pin, leaving resetn high
    for (int i = 0; i < 4; i++) begin
      boot(1'b1, lvs[i], i[0]);
      check_all(lvs[i], mds[i]);
      $display("strap set %0d done", i);
    end
    tally_and_finish();
  end
endmodule // phy_strap_latch_test

// file: dv/psl_strap_latch_assertions.sv
// port checker for the strap latch
// assumes bind onto psl_strap_latch, single clock domain
`timescale 1ns/1ps
module psl_strap_latch_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [psl_pkg::NPINS-1:0] strap_in,
  input wire logic [psl_pkg::NPINS-1:0] strap_oe,
  input wire logic [4:0] mgmt_req_addr,
  input wire logic mgmt_addr_hit,
  input wire logic [4:0] mgmt_addr,
  input psl_pkg::psl_mode_e if_mode,
  input wire logic cfg_reserved,
  input wire logic [15:0] ctrl_word,
  input wire logic [15:0] adv_word,
  input wire logic straps_done
);
  import psl_pkg::*;
  function automatic psl_mode_e mode_of(input logic [2:0] c);
    mode_of = (c == 3'b000) ? MODE_MII : (c == 3'b100) ? MODE_PRE_RESTORE : (c == 3'b110) ? MODE_B2B : MODE_RSVD;
  endfunction
  logic [NPINS-1:0] p;
  always_ff @(posedge clk) p <= strap_in;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence latch_s;
    $rose(straps_done);
  endsequence
  sequence apb_answer_s;
    pready ##1 !pready;
  endsequence
  addr_top_a: assert property (mgmt_addr[4:3] == 2'b00)
    else $error("upper address bits set");
  strap_dir_a: assert property (strap_oe == {NPINS{straps_done}})
    else $error("pin direction wrong");
  latch_addr_a: assert property (latch_s |-> mgmt_addr == {2'b00, p[2:0]})
    else $error("address not latched");
  latch_mode_a: assert property (latch_s |-> cfg_reserved == !(p[5:3] inside {3'b000, 3'b100, 3'b110}))
    else $error("reserved flag wrong");
  latch_cfg_a: assert property (latch_s |-> if_mode == mode_of(p[5:3]))
    else $error("interface mode not latched");
  latch_ctrl_a: assert property (latch_s |-> ctrl_word == {2'b00, p[7], p[9], 1'b0, p[6], 1'b0, p[8], 8'h00})
    else $error("control preset wrong");
  latch_adv_a: assert property (latch_s |-> adv_word == {7'h00, p[7], p[7], 2'b11, 5'h01})
    else $error("advert preset wrong");
  ctrl_hold_a: assert property (straps_done && !(psel && penable && pwrite) |=> $stable(ctrl_word))
    else $error("control moved without write");
  addr_hit_a: assert property (straps_done |=> mgmt_addr_hit == ($past(mgmt_req_addr) == MGMT_BCAST
    || $past(mgmt_req_addr) == $past(mgmt_addr)))
    else $error("address match wrong");
  apb_resp_a: assert property (psel && !penable && !pready |=> apb_answer_s)
    else $error("apb answer timing wrong");
endmodule // psl_strap_latch_assertions
bind psl_strap_latch psl_strap_latch_assertions chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .strap_in(strap_in), .strap_oe(strap_oe), .mgmt_req_addr(mgmt_req_addr),
  .mgmt_addr_hit(mgmt_addr_hit), .mgmt_addr(mgmt_addr), .if_mode(if_mode), .cfg_reserved(cfg_reserved),
  .ctrl_word(ctrl_word), .adv_word(adv_word), .straps_done(straps_done));

// file: dv/psl_strap_model.sv
// board-side strap model: pulls, optional reset-time driver
// assumes strap_oe/strap_out come from the latch, one bit per pin
`timescale 1ns/1ps
module psl_strap_model (
  input wire logic drv,
  input wire logic [psl_pkg::NPINS-1:0] lv,
  input wire logic [psl_pkg::NPINS-1:0] strap_oe,
  input wire logic [psl_pkg::NPINS-1:0] strap_out,
  output logic [psl_pkg::NPINS-1:0] strap_in
);
  import psl_pkg::*;
  // released pins take lv while drv is high and the pull levels otherwise, never the last level
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      strap_in[i] = strap_oe[i] ? strap_out[i] : drv ? lv[i] : PIN_PULL_LEVELS[i];
    end
  end
endmodule // psl_strap_model

// file: rtl/psl_pkg.sv
// strap latch package: register map, strap pin layout, reset values, timing
// assumes a 10 MHz device clock and a 32-bit APB register port
// ----------------------------------------------------------------------------
// Notes on behaviour
// - the three low management address straps are sampled in reset and held, giving any address 0 to 7.
// - management address bits 4 and 3 always read zero whatever the pins show.
// - the three interface straps pick plain MII (000), preamble restore (100) or back-to-back (110); others are reserved.
// - the isolate strap is copied into control bit 10, high meaning isolate enabled.
// - the speed strap is copied into control bit 13, high meaning 100Mbps.
// - the latched speed strap also presets the 100M speed abilities advertised in the advertisement register.
// - the duplex strap is copied into control bit 8, high meaning half duplex.
// - the auto-negotiation strap is copied into control bit 12, high meaning enabled.
// - strap pins are inputs during reset and outputs afterwards, so outside drivers act only in reset.
// - management accesses to broadcast address 0 are answered as well as to the strapped address.
// ----------------------------------------------------------------------------
package psl_pkg;

  // ----------------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ADV = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STRAP = 8'h08;

  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_ANEG_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;
  localparam logic [15:0] CTRL_BASE = 16'h0000;

  localparam int ADV_100FD_BIT = 8;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;
  localparam logic [15:0] ADV_BASE = 16'h0001;

  // strap status word layout
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_CFG_LSB = 8;
  localparam int STAT_RSVD_BIT = 11;
  localparam int STAT_DONE_BIT = 16;

  // ----------------------------------------------------------------------------
  // strap pin layout
  // ----------------------------------------------------------------------------
  localparam int NPINS = 10;
  localparam int PIN_ADDR_LSB = 0;
  localparam int PIN_CFG_LSB = 3;
  localparam int PIN_ISO = 6;
  localparam int PIN_SPEED = 7;
  localparam int PIN_DUPLEX = 8;
  localparam int PIN_ANEG = 9;
  // levels the pulls give with nothing driving: addr 001, speed/duplex/aneg up
  localparam logic [NPINS-1:0] PIN_PULL_LEVELS = 10'h381;

  localparam logic [2:0] CFG_MII = 3'b000;
  localparam logic [2:0] CFG_PRE_RESTORE = 3'b100;
  localparam logic [2:0] CFG_B2B = 3'b110;

  localparam logic [4:0] MGMT_ADDR_RST = 5'h01;
  localparam logic [4:0] MGMT_BCAST = 5'h00;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_CYC_I);

  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b00,
    PH_LATCH = 2'b01,
    PH_RUN = 2'b11
  } psl_phase_e;

  typedef enum logic [1:0] {
    MODE_MII = 2'b00,
    MODE_PRE_RESTORE = 2'b01,
    MODE_B2B = 2'b10,
    MODE_RSVD = 2'b11
  } psl_mode_e;

endpackage

// file: rtl/psl_strap_latch.sv
// strap latch: samples strap pins in reset, presets control and advert words
// assumes APB master on clk, strap pins and chip reset pin asynchronous
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module psl_strap_latch
  import psl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_rst_pin_n,
  input wire logic [psl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [psl_pkg::NPINS-1:0] strap_in,
  output logic [psl_pkg::NPINS-1:0] strap_out,
  output logic [psl_pkg::NPINS-1:0] strap_oe,
  input wire logic [psl_pkg::NPINS-1:0] func_out,
  input wire logic [4:0] mgmt_req_addr,
  output logic mgmt_addr_hit,
  output logic [4:0] mgmt_addr,
  output psl_pkg::psl_mode_e if_mode,
  output logic cfg_reserved,
  output logic [15:0] ctrl_word,
  output logic [15:0] adv_word,
  output logic straps_done
);

  import psl_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  // register select decoded once from paddr, shared by read and write paths
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_ADV = 2'b10,
    SEL_STRAP = 2'b11
  } psl_sel_e;

  typedef struct packed {
    psl_phase_e phase;
    logic [CNT_W-1:0] cnt;
    logic [2:0] addr_lo;
    logic [2:0] cfg;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic hit;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [4:0] maddr;
    psl_mode_e mode;
    logic rsvd;
    logic done;
  } psl_state_s;

  psl_state_s st_reg;
  psl_state_s st_next;

  logic [NPINS-1:0] strap_lvl;
  logic chip_rst_lvl_n;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic psl_mode_e cfg_decode(input logic [2:0] code);
    case (code)
      CFG_MII: cfg_decode = MODE_MII;
      CFG_PRE_RESTORE: cfg_decode = MODE_PRE_RESTORE;
      CFG_B2B: cfg_decode = MODE_B2B;
      default: cfg_decode = MODE_RSVD;
    endcase
  endfunction

  function automatic logic [4:0] full_addr(input logic [2:0] lo);
    full_addr = {2'b00, lo};
  endfunction

  function automatic psl_sel_e reg_decode(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CTRL: reg_decode = SEL_CTRL;
      ADDR_ADV: reg_decode = SEL_ADV;
      ADDR_STRAP: reg_decode = SEL_STRAP;
      default: reg_decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] ctrl_preset(input logic [NPINS-1:0] lv);
    logic [15:0] c;
    c = CTRL_BASE;
    c[CTRL_ISO_BIT] = lv[PIN_ISO];
    c[CTRL_SPEED_BIT] = lv[PIN_SPEED];
    c[CTRL_DUPLEX_BIT] = lv[PIN_DUPLEX];
    c[CTRL_ANEG_BIT] = lv[PIN_ANEG];
    ctrl_preset = c;
  endfunction

  // 10M abilities always offered; only the 100M pair follows the speed strap
  function automatic logic [15:0] adv_preset(input logic [NPINS-1:0] lv);
    logic [15:0] a;
    a = ADV_BASE;
    a[ADV_100FD_BIT] = lv[PIN_SPEED];
    a[ADV_100HD_BIT] = lv[PIN_SPEED];
    a[ADV_10FD_BIT] = 1'b1;
    a[ADV_10HD_BIT] = 1'b1;
    adv_preset = a;
  endfunction

  function automatic logic [31:0] strap_status(input psl_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STAT_ADDR_LSB +: 5] = full_addr(s.addr_lo);
    w[STAT_CFG_LSB +: 3] = s.cfg;
    w[STAT_RSVD_BIT] = (cfg_decode(s.cfg) == MODE_RSVD);
    w[STAT_DONE_BIT] = (s.phase == PH_RUN);
    strap_status = w;
  endfunction

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  psl_sync #(
    .WIDTH(NPINS),
    .RST_VAL(PIN_PULL_LEVELS)
  ) u_strap_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(strap_in),
    .level_out(strap_lvl)
  );

  psl_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(chip_rst_pin_n),
    .level_out(chip_rst_lvl_n)
  );

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    psl_sel_e sel;
    logic mapped;
    logic ro;
    sel = reg_decode(paddr);
    mapped = 1'b0;
    ro = 1'b0;
    st_next = st_reg;

    // ----------------------------------------------------------------------------
    // strap phase sequencing
    // ----------------------------------------------------------------------------
    case (st_reg.phase)
      PH_SAMPLE: begin
        st_next.pin_oe = '0;
        if (!chip_rst_lvl_n) begin
          st_next.cnt = '0;
        end else if (st_reg.cnt >= SETTLE_CYC - CNT_W'(1)) begin
          // window outlasts the synchroniser delay after the pin releases
          st_next.phase = PH_LATCH;
        end else begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      PH_LATCH: begin
        st_next.addr_lo = strap_lvl[PIN_ADDR_LSB +: 3];
        st_next.cfg = strap_lvl[PIN_CFG_LSB +: 3];
        st_next.ctrl = ctrl_preset(strap_lvl);
        st_next.adv = adv_preset(strap_lvl);
        st_next.cnt = '0;
        // pins turn to outputs at the same edge that raises straps_done
        st_next.pin_oe = {NPINS{1'b1}};
        st_next.phase = PH_RUN;
      end
      PH_RUN: begin
        st_next.pin_oe = {NPINS{1'b1}};
        if (!chip_rst_lvl_n) begin
          st_next.phase = PH_SAMPLE;
          st_next.pin_oe = '0;
        end
      end
      default: begin
        st_next.phase = PH_SAMPLE;
        st_next.pin_oe = '0;
      end
    endcase
    st_next.pin_out = func_out;

    // ----------------------------------------------------------------------------
    // management address match, strapped or broadcast
    // ----------------------------------------------------------------------------
    st_next.hit = (mgmt_req_addr == full_addr(st_reg.addr_lo)) || (mgmt_req_addr == MGMT_BCAST);

    // ----------------------------------------------------------------------------
    // apb slave: answer in the first cycle of the access phase, no wait states
    // ----------------------------------------------------------------------------
    st_next.ready = 1'b0;
    if (psel && !penable && !st_reg.ready) begin
      case (sel)
        SEL_CTRL: begin
          mapped = 1'b1;
          st_next.rdata = {16'h0000, st_reg.ctrl};
        end
        SEL_ADV: begin
          mapped = 1'b1;
          st_next.rdata = {16'h0000, st_reg.adv};
        end
        SEL_STRAP: begin
          mapped = 1'b1;
          ro = 1'b1;
          st_next.rdata = strap_status(st_reg);
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
      // writes before the straps are latched would be overwritten, so refuse them
      st_next.err = !mapped || (pwrite && (ro || st_reg.phase != PH_RUN));
      if (pwrite) begin
        st_next.rdata = 32'h0000_0000;
      end
      st_next.ready = 1'b1;
    end

    // ----------------------------------------------------------------------------
    // access phase: a granted write lands
    // ----------------------------------------------------------------------------
    // a relatch begun between setup and access cancels the write
    if (st_reg.ready && psel && penable && pwrite && !st_reg.err && st_reg.phase == PH_RUN) begin
      if (sel == SEL_CTRL) begin
        st_next.ctrl = pwdata[15:0];
      end else if (sel == SEL_ADV) begin
        st_next.adv = pwdata[15:0];
      end
    end
    if (!st_next.ready) begin
      st_next.err = 1'b0;
    end

    // ----------------------------------------------------------------------------
    // registered copies of decoded outputs
    // ----------------------------------------------------------------------------
    // decoded here so every output leaves a flip-flop
    st_next.maddr = full_addr(st_next.addr_lo);
    st_next.mode = cfg_decode(st_next.cfg);
    st_next.rsvd = (cfg_decode(st_next.cfg) == MODE_RSVD);
    st_next.done = (st_next.phase == PH_RUN);
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.phase <= PH_SAMPLE;
      st_reg.cnt <= '0;
      st_reg.addr_lo <= MGMT_ADDR_RST[2:0];
      st_reg.cfg <= CFG_MII;
      st_reg.ctrl <= CTRL_BASE;
      st_reg.adv <= ADV_BASE;
      st_reg.pin_out <= '0;
      st_reg.pin_oe <= '0;
      st_reg.hit <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.ready <= 1'b0;
      st_reg.err <= 1'b0;
      st_reg.maddr <= MGMT_ADDR_RST;
      st_reg.mode <= MODE_MII;
      st_reg.rsvd <= 1'b0;
      st_reg.done <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign strap_out = st_reg.pin_out;
  assign strap_oe = st_reg.pin_oe;
  assign mgmt_addr_hit = st_reg.hit;
  assign mgmt_addr = st_reg.maddr;
  assign if_mode = st_reg.mode;
  assign cfg_reserved = st_reg.rsvd;
  assign ctrl_word = st_reg.ctrl;
  assign adv_word = st_reg.adv;
  assign straps_done = st_reg.done;

endmodule // psl_strap_latch

// file: rtl/psl_sync.sv
// three-stage synchroniser for pin levels, output moves when stages 2 and 3 agree
// assumes the inputs are asynchronous pins and clk is the device clock
`timescale 1ns/1ps
module psl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } psl_sync_s;

  psl_sync_s st_reg;
  psl_sync_s st_next;

  // ----------------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // s1 feeds only s2; bits change only where the later stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.level[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule // psl_sync
